// ==== logic/nv_data_guard_and_config.v ====
`timescale 1ns/1ns
`include "nv_guard_regs.vh"

module nv_data_guard_and_config #(
  parameter [7:0] MAKER_SIG = 8'h5a,   // Arbitrary value.
  parameter [7:0] DEVICE_SIG = 8'h3c,  // Arbitrary value.
  parameter [7:0] VARIANT_SIG = 8'h01  // Arbitrary value.
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Core command and data register port.
  input wire cmd_wr,
  input wire [7:0] cmd_wdata,
  output reg [7:0] cmd_rdata,
  input wire data_wr,
  input wire [7:0] data_wdata,
  input wire [1:0] page_sel,
  // Operations handed to the store array.
  output reg op_erase,
  output reg op_write,
  output reg op_checksum,
  output reg op_buf_clear,
  output reg op_refused,
  output reg [1:0] op_page,
  output reg overlay_on,
  // Programmer configuration access.
  input wire in_circuit_programming_mode,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  // Clock setup.
  input wire double_speed_bit,
  output reg six_clock_mode,
  output reg xtal_disable,
  // Code space address steering.
  input wire [15:0] fetch_addr,
  input wire [15:0] table_addr,
  input wire table_from_external,
  output reg [15:0] fetch_addr_out,
  output reg [15:0] table_addr_out,
  output reg table_to_store,
  output reg table_force_blank,
  output reg code_write_block
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bytes.

  reg [7:0] setup_reg;
  reg [7:0] lock_reg;
  reg [7:0] guard_reg [0:`STORE_PAGES-1];
  reg [7:0] cfg_rdata_next;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_reg <= `SETUP_RESET;
      lock_reg <= `LOCK_RESET;
    end else if (cfg_wr && in_circuit_programming_mode) begin
      // Reserved bits are masked so they always read back as zero.
      if (cfg_addr == `CFG_SETUP_ADDR) begin
        setup_reg <= cfg_wdata & `SETUP_USED_MASK;
      end
      if (cfg_addr == `CFG_LOCK_ADDR) begin
        lock_reg <= cfg_wdata & `LOCK_USED_MASK;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `STORE_PAGES; g = g + 1) begin : guard_bytes
      localparam [7:0] GUARD_ADDR = `CFG_PAGE0_ADDR + g;
      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          guard_reg[g] <= `GUARD_RESET;
        end else if (cfg_wr && in_circuit_programming_mode &&
                     cfg_addr == GUARD_ADDR) begin
          guard_reg[g] <= cfg_wdata & `GUARD_USED_MASK;
        end
      end
    end
  endgenerate

  // Unmapped addresses read as blank so a programmer sees an erased cell.
  always @* begin
    case (cfg_addr)
      `CFG_SETUP_ADDR: cfg_rdata_next = setup_reg;
      `CFG_LOCK_ADDR: cfg_rdata_next = lock_reg;
      `CFG_PAGE0_ADDR: cfg_rdata_next = guard_reg[0];
      `CFG_PAGE1_ADDR: cfg_rdata_next = guard_reg[1];
      `CFG_PAGE2_ADDR: cfg_rdata_next = guard_reg[2];
      `CFG_MAKER_ADDR: cfg_rdata_next = MAKER_SIG;
      `CFG_DEVICE_ADDR: cfg_rdata_next = DEVICE_SIG;
      `CFG_VARIANT_ADDR: cfg_rdata_next = VARIANT_SIG;
      default: cfg_rdata_next = `BLANK_BYTE;
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd && in_circuit_programming_mode) begin
      cfg_rdata <= cfg_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-allow flag and its key sequence.

  reg we_reg;
  reg we_next;
  reg armed_reg;
  reg armed_next;
  wire forced_write_allow_cfg = setup_reg[`SETUP_FORCED_WRITE_ALLOW_BIT];
  wire write_allow = we_reg | forced_write_allow_cfg | in_circuit_programming_mode;

  always @* begin
    we_next = we_reg;
    armed_next = armed_reg;
    if (cmd_wr) begin
      // Any other command disarms, so the key has to follow the set command directly.
      armed_next = (cmd_wdata == `CMD_FLAG_SET);
      if (cmd_wdata == `CMD_FLAG_CLEAR) begin
        we_next = 1'b0;
      end
    end else if (data_wr && armed_reg) begin
      // Any data write ends the armed window, so a stale arm cannot be replayed.
      armed_next = 1'b0;
      if (data_wdata == `FLAG_KEY) begin
        we_next = 1'b1;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Only the stored flag and the arm reset here; forced sources are ORed in after them.
      we_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      we_reg <= we_next;
      armed_reg <= armed_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and page guards.

  wire page_valid = (page_sel < `STORE_PAGES);
  wire [7:0] page_guard = page_valid ? guard_reg[page_sel] : 8'h00;
  wire run_mode = ~in_circuit_programming_mode;
  // Programming mode bypasses the flag and the run erase guard, but page writes still obey the write guard.
  wire store_write_ok = ~run_mode | write_allow;
  wire erase_guarded = page_guard[`GUARD_RUN_ERASE_BIT] & run_mode;
  wire write_guarded = page_guard[`GUARD_PAGE_WRITE_BIT];
  // A page without its write guard refuses the checksum, hence the inversion.
  wire checksum_guarded = ~page_guard[`GUARD_PAGE_WRITE_BIT];

  reg erase_next;
  reg write_next;
  reg checksum_next;
  reg buf_clear_next;
  reg refused_next;
  reg overlay_next;
  reg refused_flag_reg;
  reg refused_flag_next;

  always @* begin
    erase_next = 1'b0;
    write_next = 1'b0;
    checksum_next = 1'b0;
    buf_clear_next = 1'b0;
    refused_next = 1'b0;
    overlay_next = overlay_on;
    if (cmd_wr) begin
      case (cmd_wdata)
        `CMD_PAGE_ERASE: begin
          if (page_valid && store_write_ok && !erase_guarded) begin
            erase_next = 1'b1;
          end else begin
            refused_next = 1'b1;
          end
        end
        `CMD_PAGE_WRITE: begin
          if (page_valid && store_write_ok && !write_guarded) begin
            write_next = 1'b1;
          end else begin
            refused_next = 1'b1;
          end
        end
        `CMD_ERASE_THEN_WRITE: begin
          if (page_valid && store_write_ok && !write_guarded) begin
            erase_next = 1'b1;
            write_next = 1'b1;
          end else begin
            refused_next = 1'b1;
          end
        end
        `CMD_PAGE_CHECKSUM: begin
          if (page_valid && !checksum_guarded) begin
            checksum_next = 1'b1;
          end else begin
            refused_next = 1'b1;
          end
        end
        `CMD_BUF_CLEAR: buf_clear_next = 1'b1;
        `CMD_OVERLAY_ON: overlay_next = 1'b1;
        `CMD_OVERLAY_OFF: overlay_next = 1'b0;
        default: ;
      endcase
    end
  end

  // The refused flag reports the most recent command; a new command restarts it.
  always @* begin
    refused_flag_next = refused_flag_reg;
    if (cmd_wr) begin
      refused_flag_next = refused_next;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_erase <= 1'b0;
      op_write <= 1'b0;
      op_checksum <= 1'b0;
      op_buf_clear <= 1'b0;
      op_refused <= 1'b0;
      op_page <= 2'h0;
      overlay_on <= 1'b0;
      refused_flag_reg <= 1'b0;
    end else begin
      // Each operation pulse lasts one cycle; op_page stands until the next command.
      op_erase <= erase_next;
      op_write <= write_next;
      op_checksum <= checksum_next;
      op_buf_clear <= buf_clear_next;
      op_refused <= refused_next;
      if (cmd_wr) begin
        op_page <= page_sel;
      end
      overlay_on <= overlay_next;
      refused_flag_reg <= refused_flag_next;
    end
  end

  // Status read-back; the flag bit shows the effective state, forced or not.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_rdata <= 8'h00;
    end else begin
      cmd_rdata <= 8'h00;
      cmd_rdata[`STAT_WRITE_ALLOW_BIT] <= write_allow;
      cmd_rdata[`STAT_OVERLAY_BIT] <= overlay_on;
      cmd_rdata[`STAT_REFUSED_BIT] <= refused_flag_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock setup outputs.

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      six_clock_mode <= 1'b0;
      xtal_disable <= 1'b0;
    end else begin
      // Either the force bit or the clock control bit selects 6-clock mode.
      six_clock_mode <= setup_reg[`SETUP_FORCE_DOUBLE_SPEED_BIT] | double_speed_bit;
      xtal_disable <= setup_reg[`SETUP_EXTERNAL_CLOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code space steering for fetches and table reads.

  wire internal_only_execution = lock_reg[`LOCK_INTERNAL_ONLY_BIT];
  wire code_lock_bit = lock_reg[`LOCK_CODE_LOCK_BIT];
  // Wrapping drops the upper address bits, so internal code repeats across the space.
  wire [15:0] wrap_mask = `INTERNAL_CODE_TOP - 16'h0001;
  wire table_in_window = (table_addr >= `STORE_WINDOW_BASE);
  wire store_hit = (internal_only_execution | overlay_on) & table_in_window;
  wire [1:0] store_page = table_addr[7:6];
  wire store_page_ok = (store_page < `STORE_PAGES);
  wire [7:0] hit_guard = store_page_ok ? guard_reg[store_page] : 8'h00;
  wire table_internal = internal_only_execution | (table_addr < `INTERNAL_CODE_TOP);

  // Table reads from external code into a locked store page or locked code see blank.
  wire blank_store = store_hit & (~store_page_ok |
                     (table_from_external & hit_guard[`GUARD_EXT_READ_BIT]));
  wire blank_code = ~store_hit & table_from_external & code_lock_bit & table_internal;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_addr_out <= 16'h0000;
      table_addr_out <= 16'h0000;
      table_to_store <= 1'b0;
      table_force_blank <= 1'b0;
      code_write_block <= 1'b0;
    end else begin
      fetch_addr_out <= internal_only_execution ? (fetch_addr & wrap_mask) : fetch_addr;
      // Store hits keep the full address, as the page comes from bits 7 to 6.
      if (store_hit) begin
        table_addr_out <= table_addr;
      end else if (internal_only_execution) begin
        table_addr_out <= table_addr & wrap_mask;
      end else begin
        table_addr_out <= table_addr;
      end
      table_to_store <= store_hit;
      table_force_blank <= blank_store | blank_code;
      code_write_block <= code_lock_bit;
    end
  end

endmodule

// ==== logic/nv_guard_regs.vh ====
`ifndef NV_GUARD_REGS_VH
`define NV_GUARD_REGS_VH

// Configuration byte addresses on the programmer access port.
`define CFG_SETUP_ADDR 8'h00
`define CFG_LOCK_ADDR 8'h01
`define CFG_PAGE0_ADDR 8'h02
`define CFG_PAGE1_ADDR 8'h03
`define CFG_PAGE2_ADDR 8'h04
`define CFG_MAKER_ADDR 8'h10
`define CFG_DEVICE_ADDR 8'h11
`define CFG_VARIANT_ADDR 8'h12

// Command codes written to the command register; FLAG_KEY goes to the data register.
`define CMD_BUF_CLEAR 8'h00
`define CMD_FLAG_SET 8'h08
`define CMD_OVERLAY_ON 8'h09
`define CMD_OVERLAY_OFF 8'h0a
`define CMD_FLAG_CLEAR 8'h0b
`define CMD_PAGE_CHECKSUM 8'h1d
`define CMD_PAGE_ERASE 8'h33
`define CMD_PAGE_WRITE 8'h48
`define CMD_ERASE_THEN_WRITE 8'h68
`define FLAG_KEY 8'h96

// Command register status bits.
`define STAT_WRITE_ALLOW_BIT 6
`define STAT_REFUSED_BIT 0
`define STAT_OVERLAY_BIT 1

// Setup byte fields.
`define SETUP_FORCED_WRITE_ALLOW_BIT 2
`define SETUP_FORCE_DOUBLE_SPEED_BIT 1
`define SETUP_EXTERNAL_CLOCK_BIT 0
`define SETUP_USED_MASK 8'h07

// Code lock byte fields.
`define LOCK_INTERNAL_ONLY_BIT 1
`define LOCK_CODE_LOCK_BIT 0
`define LOCK_USED_MASK 8'h03

// Page guard byte fields.
`define GUARD_RUN_ERASE_BIT 2
`define GUARD_PAGE_WRITE_BIT 1
`define GUARD_EXT_READ_BIT 0
`define GUARD_USED_MASK 8'h07

// Reset images of the configuration bytes and read-back fill.
`define SETUP_RESET 8'h00
`define LOCK_RESET 8'h00
`define GUARD_RESET 8'h00
`define BLANK_BYTE 8'hff

// Address map of the code side.
`define STORE_WINDOW_BASE 16'hff00
`define INTERNAL_CODE_TOP 16'h2000
`define STORE_PAGES 3

`endif

// ==== tb/nv_guard_asserts.sv ====
`timescale 1ns/1ns
module nv_guard_asserts (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Command side.
  input wire cmd_wr,
  input wire [7:0] cmd_wdata,
  input wire [7:0] cmd_rdata,
  input wire op_erase,
  input wire op_write,
  input wire op_checksum,
  input wire op_buf_clear,
  input wire op_refused,
  input wire overlay_on,
  // Programmer and clock side.
  input wire in_circuit_programming_mode,
  input wire cfg_rd,
  input wire [7:0] cfg_rdata,
  input wire double_speed_bit,
  input wire six_clock_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_erase_cause:
    assert property (op_erase |-> $past(cmd_wr) && ($past(cmd_wdata) == 8'h33
      || $past(cmd_wdata) == 8'h68)) else $error("erase without its command");
  a_write_cause:
    assert property (op_write |-> $past(cmd_wr) && ($past(cmd_wdata) == 8'h48
      || $past(cmd_wdata) == 8'h68)) else $error("write without its command");
  a_erase_write_pair:
    assert property (op_write && $past(cmd_wdata) == 8'h68 |-> op_erase)
      else $error("erase-then-write lost its erase");
  a_checksum_cause:
    assert property (op_checksum |-> $past(cmd_wr) && $past(cmd_wdata) == 8'h1d)
      else $error("checksum without its command");
  a_buf_clear:
    assert property (cmd_wr && cmd_wdata == 8'h00 |=> op_buf_clear)
      else $error("buffer clear missing");
  a_refused_quiet:
    assert property (op_refused |-> !op_erase && !op_write && !op_checksum)
      else $error("refused command still issued");
  a_overlay_set:
    assert property (cmd_wr && cmd_wdata == 8'h09 |=> ##[0:1] overlay_on)
      else $error("overlay not set");
  a_overlay_clear:
    assert property (cmd_wr && cmd_wdata == 8'h0a |=> ##[0:1] !overlay_on)
      else $error("overlay not removed");
  a_cfg_quiet:
    assert property (cfg_rd && !in_circuit_programming_mode |=> $stable(cfg_rdata))
      else $error("config read honoured in run mode");
  a_six_clock:
    assert property (!sys_rst && double_speed_bit |=> six_clock_mode)
      else $error("double speed ignored");
  a_prog_flag:
    assert property (in_circuit_programming_mode [*3] |-> cmd_rdata[6])
      else $error("write allow low in programming mode");
endmodule

bind nv_data_guard_and_config nv_guard_asserts u_asserts (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
  .cmd_rdata(cmd_rdata), .op_erase(op_erase), .op_write(op_write),
  .op_checksum(op_checksum), .op_buf_clear(op_buf_clear), .op_refused(op_refused),
  .overlay_on(overlay_on), .in_circuit_programming_mode(in_circuit_programming_mode),
  .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .double_speed_bit(double_speed_bit),
  .six_clock_mode(six_clock_mode)
);

// ==== tb/nv_core_model.sv ====
`timescale 1ns/1ns
module nv_core_model (
  // Clock.
  input wire sys_clk,
  // Core register writes.
  output reg cmd_wr,
  output reg [7:0] cmd_wdata,
  output reg data_wr,
  output reg [7:0] data_wdata,
  output reg [1:0] page_sel,
  // Programmer access.
  output reg cfg_wr,
  output reg cfg_rd,
  output reg [7:0] cfg_addr,
  output reg [7:0] cfg_wdata
);
  initial begin
    {cmd_wr, data_wr, cfg_wr, cfg_rd} = 4'h0;
    {cmd_wdata, data_wdata, cfg_addr, cfg_wdata} = 32'h0;
    page_sel = 2'h0;
  end

  // Released data lines are inverted so a stale value is never mistaken for a live one.
  task cmd(input [7:0] c, input [1:0] p);
    begin
      @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_wdata <= c;
      page_sel <= p;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      cmd_wdata <= ~c;
      page_sel <= ~p;
    end
  endtask

  task unlock(input [7:0] key);
    begin
      cmd(8'h08, 2'h0);
      @(posedge sys_clk);
      data_wr <= 1'b1;
      data_wdata <= key;
      @(posedge sys_clk);
      data_wr <= 1'b0;
      data_wdata <= ~key;
    end
  endtask

  // Only meaningful while the programming mode input is high.
  task cfg(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      cfg_wr <= w;
      cfg_rd <= ~w;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge sys_clk);
      {cfg_wr, cfg_rd} <= 2'b00;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
    end
  endtask
endmodule

// ==== tb/nv_data_guard_and_config_tb_top.sv ====
`timescale 1ns/1ns
module nv_data_guard_and_config_tb_top;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg in_circuit_programming_mode = 1'b0;
  reg double_speed_bit = 1'b0;
  reg table_from_external = 1'b0;
  reg [15:0] fetch_addr = 16'h0000;
  reg [15:0] table_addr = 16'h0000;
  reg [4:0] ops;
  reg [12:0] r;
  integer failures = 0;
  integer checked = 0;
  integer i;
  wire cmd_wr, data_wr, cfg_wr, cfg_rd, op_erase, op_write, op_checksum, op_buf_clear;
  wire op_refused, overlay_on, six_clock_mode, xtal_disable, table_to_store;
  wire table_force_blank, code_write_block;
  wire [1:0] page_sel, op_page;
  wire [7:0] cmd_wdata, cmd_rdata, data_wdata, cfg_addr, cfg_wdata, cfg_rdata;
  wire [15:0] fetch_addr_out, table_addr_out;

  always #5 sys_clk = ~sys_clk;

  nv_core_model core (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .data_wr(data_wr), .data_wdata(data_wdata), .page_sel(page_sel), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));

  nv_data_guard_and_config dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .page_sel(page_sel), .op_erase(op_erase),
    .op_write(op_write), .op_checksum(op_checksum), .op_buf_clear(op_buf_clear),
    .op_refused(op_refused), .op_page(op_page), .overlay_on(overlay_on),
    .in_circuit_programming_mode(in_circuit_programming_mode),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .double_speed_bit(double_speed_bit), .six_clock_mode(six_clock_mode),
    .xtal_disable(xtal_disable), .fetch_addr(fetch_addr), .table_addr(table_addr),
    .table_from_external(table_from_external), .fetch_addr_out(fetch_addr_out),
    .table_addr_out(table_addr_out), .table_to_store(table_to_store),
    .table_force_blank(table_force_blank), .code_write_block(code_write_block));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask

  // Latency of the operation pulses is not pinned here, so three cycles are gathered.
  task run(input [7:0] c, input [1:0] p);
    begin
      core.cmd(c, p);
      #1 ops = {op_erase, op_write, op_checksum, op_buf_clear, op_refused};
      repeat (2) begin
        @(posedge sys_clk);
        #1 ops = ops | {op_erase, op_write, op_checksum, op_buf_clear, op_refused};
      end
    end
  endtask

  function [12:0] row(input integer k);
    case (k)
      0: row = {8'h00, 5'h02};
      1: row = {8'h1d, 5'h01};
      2: row = {8'h33, 5'h10};
      3: row = {8'h48, 5'h08};
      default: row = {8'h68, 5'h18};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task t_flag;
    begin
      chk({cmd_rdata[6], six_clock_mode}, 2'b00);
      run(8'h33, 2'd0);
      chk(ops, 5'h01);
      core.unlock(8'h55);
      tick(3);
      chk(cmd_rdata[6], 1'b0);
      core.unlock(8'h96);
      tick(3);
      chk(cmd_rdata[6], 1'b1);
      run(8'h33, 2'd2);
      chk({ops, op_page, cmd_rdata[0]}, {5'h10, 2'd2, 1'b0});
      run(8'h0b, 2'd0);
      chk(cmd_rdata[6], 1'b0);
    end
  endtask

  task t_codes;
    begin
      core.unlock(8'h96);
      for (i = 0; i < 5; i = i + 1) begin
        r = row(i);
        run(r[12:5], 2'd1);
        chk(ops, r[4:0]);
      end
      run(8'h09, 2'd0);
      chk({overlay_on, cmd_rdata[1]}, 2'b11);
      run(8'h0a, 2'd0);
      chk({overlay_on, cmd_rdata[1]}, 2'b00);
    end
  endtask

  task t_guard;
    begin
      run(8'h0b, 2'd0);
      @(posedge sys_clk);
      in_circuit_programming_mode <= 1'b1;
      core.cfg(1'b1, 8'h03, 8'hff);
      core.cfg(1'b1, 8'h00, 8'h07);
      core.cfg(1'b1, 8'h01, 8'h03);
      core.cfg(1'b0, 8'h03, 8'h00);
      tick(2);
      chk(cfg_rdata, 8'h07);
      core.cfg(1'b0, 8'h20, 8'h00);
      tick(2);
      chk(cfg_rdata, 8'hff);
      run(8'h33, 2'd1);
      chk(ops, 5'h10);
      run(8'h48, 2'd1);
      chk({ops, cmd_rdata[0]}, {5'h01, 1'b1});
      @(posedge sys_clk);
      in_circuit_programming_mode <= 1'b0;
      core.cfg(1'b0, 8'h00, 8'h00);
      tick(3);
      chk({cfg_rdata, 7'h00, cmd_rdata[6]}, {8'hff, 8'h01});
      run(8'h33, 2'd1);
      chk(ops, 5'h01);
      run(8'h1d, 2'd1);
      chk(ops, 5'h04);
      run(8'h68, 2'd1);
      chk(ops, 5'h01);
      run(8'h48, 2'd0);
      chk(ops, 5'h08);
    end
  endtask

  task t_steer;
    begin
      @(posedge sys_clk);
      table_from_external <= 1'b1;
      table_addr <= 16'hff45;
      fetch_addr <= 16'h3123;
      tick(3);
      chk({table_to_store, table_force_blank, six_clock_mode, xtal_disable,
        code_write_block}, 5'h1f);
      chk(fetch_addr_out, 16'h1123);
      chk(table_addr_out, 16'hff45);
      @(posedge sys_clk);
      table_addr <= 16'h2100;
      tick(3);
      chk({table_to_store, table_force_blank}, 2'b01);
      chk(table_addr_out, 16'h0100);
      @(posedge sys_clk);
      table_from_external <= 1'b0;
      double_speed_bit <= 1'b1;
      tick(3);
      chk({table_to_store, table_force_blank}, 2'b00);
    end
  endtask

  task t_reset;
    begin
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      tick(2);
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      tick(3);
      chk({xtal_disable, cmd_rdata[6], six_clock_mode, code_write_block}, 4'h2);
    end
  endtask

  task end_sim;
    begin
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // The run needs well under a thousand cycles; the margin only catches a hang.
  initial begin
    #200000;
    failures = failures + 1;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(2);
    t_flag;
    t_codes;
    t_guard;
    t_steer;
    t_reset;
    end_sim;
  end
endmodule
